// *** include/hwd_pkg.sv ***
/*
 * Package for the host watchdog command unit: bus offsets, field
 * positions, reset values, ASCII codes and timing counts.
 * Assumes a 40 MHz clock and a byte stream parsed one char at a time.
 */
package hwd_pkg;
    // Clock and timebase
    localparam int          CLK_HZ        = 40_000_000;
    localparam int          TICK_MS       = 100;
    localparam int          TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
    // Register offsets (byte addresses)
    localparam logic [3:0]  OFS_CTRL      = 4'h0;
    localparam logic [3:0]  OFS_STATUS    = 4'h4;
    localparam logic [3:0]  OFS_IRQ       = 4'h8;
    localparam logic [3:0]  OFS_MASK      = 4'hc;
    // Control register fields
    localparam int          CTRL_ADDR_LSB = 0;
    localparam int          CTRL_LEAD_LSB = 8;
    localparam logic [7:0]  ADDR_RESET    = 8'h00;
    localparam logic [7:0]  LEAD_RESET    = 8'h7e;
    // Status bits of the two-character status
    localparam int          ST_FAIL       = 1;
    localparam int          ST_ENABLED    = 2;
    localparam int          ST_HOSTFAIL   = 3;
    // Interrupt event bits
    localparam int          EV_EXPIRE     = 0;
    localparam int          EV_SET        = 1;
    localparam int          EV_BAD        = 2;
    localparam int          EV_WIDTH      = 3;
    // Watchdog reset values
    localparam logic [7:0]  TIMEOUT_RESET = 8'h01;
    localparam logic [7:0]  SAFE_RESET    = 8'h00;
    // ASCII codes
    localparam logic [7:0]  CH_CR         = 8'h0d;
    localparam logic [7:0]  CH_BANG       = 8'h21;
    localparam logic [7:0]  CH_QUERY      = 8'h3f;
    localparam logic [7:0]  CH_STAR       = 8'h2a;
    localparam logic [7:0]  CH_ZERO       = 8'h30;
    localparam logic [7:0]  CH_ONE        = 8'h31;
    localparam logic [7:0]  CH_SET        = 8'h32;
    localparam logic [7:0]  CH_READ       = 8'h33;
    // Receive buffer length: address, code and up to five data chars
    localparam int          RX_MAX        = 8;
    localparam int          TX_MAX        = 9;  // Read answer plus its CR
endpackage : hwd_pkg

// *** core/hwd_tick.sv ***
/*
 * Divider giving a one-cycle enable every 100 ms of the module clock.
 * Assumes the synchronous active-high reset of the main clock.
 */
`timescale 1ns/10ps
module hwd_tick (
    input  wire logic clk,
    input  wire logic reset,
    output logic      tick
);
    import hwd_pkg::*;

    typedef struct packed {
        logic [21:0] count;
        logic        tick;
    } hwd_tick_t;

    hwd_tick_t state_reg;
    hwd_tick_t state_next;

    // Count down to zero, pulse and reload
    always_comb begin
        state_next      = state_reg;
        state_next.tick = 1'b0;
        if (state_reg.count == 22'h0) begin
            state_next.count = 22'(TICK_CYCLES - 1);
            state_next.tick  = 1'b1;
        end else begin
            state_next.count = state_reg.count - 22'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick = state_reg.tick;
endmodule : hwd_tick

// *** core/hwd_core.sv ***
/*
 * Host watchdog command unit: parses ASCII commands from the serial
 * receiver, keeps watchdog enable, timeout and safe pattern, answers
 * reads, and forces the digital outputs on expiry.
 * Assumes a UART outside: rx bytes arrive as one-cycle strobes, tx
 * bytes leave with a valid/ready handshake. Registers over Wishbone.
 */
// Local design decisions: the register addresses and the Wishbone register port.
// Functional notes
// - Set command: lead, addr, 2, flag, timeout, safe, CR
// - Flag 0 disables, 1 enables watchdog
// - Timeout hex 01..FF, units of 100 ms
// - Expiry forces outputs to safe pattern
// - Safe field: two hex chars, eight outputs
// - Own address only, except keep-alive
// - Read 3 replies flag, timeout, 00; bad gets ?
// - Keep-alive lead, two stars, CR; never answered
// - Status bits: 1 fail, 2 enabled, 3 host fail
`timescale 1ns/10ps
module hwd_core (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    output logic      [7:0]  tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    input  wire logic [7:0]  dout_normal,
    output logic      [7:0]  dout,
    output logic             host_fail,
    output logic             irq
);
    import hwd_pkg::*;

    typedef enum logic [1:0] {
        PS_IDLE,
        PS_COLLECT,
        PS_SKIP
    } hwd_parse_t;

    typedef struct packed {
        hwd_parse_t                parse;
        logic [RX_MAX-1:0][7:0]    rx_buf;
        logic [3:0]                rx_len;
        logic [TX_MAX-1:0][7:0]    tx_buf;
        logic [3:0]                tx_len;
        logic [3:0]                tx_idx;
        logic                      wd_enable;
        logic [7:0]                timeout;
        logic [7:0]                safe_output_pattern;
        logic [7:0]                countdown;
        logic                      host_failed;
        logic                      wd_failed;
        logic [7:0]                module_addr;
        logic [7:0]                lead_char;
        logic [EV_WIDTH-1:0]       irq_status;
        logic [EV_WIDTH-1:0]       irq_mask;
        logic [31:0]               rdata;
        logic                      ack;
    } hwd_core_t;

    hwd_core_t state_reg;
    hwd_core_t state_next;
    logic      tick;

    // Hex character to nibble; valid flag in bit 4
    function automatic logic [4:0] hex_val(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39) begin
            hex_val = {1'b1, 4'(c - 8'h30)};
        end else if (c >= 8'h41 && c <= 8'h46) begin
            hex_val = {1'b1, 4'(c - 8'h37)};
        end else if (c >= 8'h61 && c <= 8'h66) begin
            hex_val = {1'b1, 4'(c - 8'h57)};
        end else begin
            hex_val = 5'h00;
        end
    endfunction : hex_val

    // Nibble to upper-case hex character
    function automatic logic [7:0] hex_chr(input logic [3:0] n);
        hex_chr = (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction : hex_chr

    hwd_tick u_tick (
        .clk   (clk),
        .reset (reset),
        .tick  (tick)
    );

    logic [4:0]  h0;
    logic [4:0]  h1;
    logic [4:0]  h2;
    logic [4:0]  h3;
    logic [4:0]  h4;
    logic [4:0]  h5;
    logic [7:0]  new_to;
    logic [7:0]  new_safe;
    logic        bus_req;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;
    logic [EV_WIDTH-1:0] ev_set;

    // Hex decode of the buffered address characters and of the four data chars after the flag
    assign h0        = hex_val(state_reg.rx_buf[0]);
    assign h1        = hex_val(state_reg.rx_buf[1]);
    assign h2        = hex_val(state_reg.rx_buf[4]);
    assign h3        = hex_val(state_reg.rx_buf[5]);
    assign h4        = hex_val(state_reg.rx_buf[6]);
    assign h5        = hex_val(state_reg.rx_buf[7]);
    assign new_to    = {h2[3:0], h3[3:0]};
    assign new_safe  = {h4[3:0], h5[3:0]};
    assign bus_req   = wb_cyc_i && wb_stb_i && !state_reg.ack;
    assign ctrl_word = {16'h0000, state_reg.lead_char,
                        state_reg.module_addr};

    // Two-character status as seen by software
    always_comb begin
        status_word              = 32'h0000_0000;
        status_word[ST_FAIL]     = state_reg.wd_failed;
        status_word[ST_ENABLED]  = state_reg.wd_enable;
        status_word[ST_HOSTFAIL] = state_reg.host_failed;
    end

    // Parser, watchdog, reply builder and bus slave
    always_comb begin
        state_next     = state_reg;
        ev_set         = '0;
        state_next.ack = 1'b0;

        // Transmit drain: one byte per accepted handshake
        if (state_reg.tx_idx < state_reg.tx_len && tx_ready) begin
            state_next.tx_idx = state_reg.tx_idx + 4'h1;
        end

        // Watchdog countdown on the 100 ms enable
        if (state_reg.wd_enable && tick && !state_reg.host_failed) begin
            if (state_reg.countdown <= 8'h01) begin
                state_next.countdown   = 8'h00;
                state_next.host_failed = 1'b1;
                state_next.wd_failed   = 1'b1;
                ev_set[EV_EXPIRE]      = 1'b1;
            end else begin
                state_next.countdown = state_reg.countdown - 8'h01;
            end
        end

        // Character parser
        if (rx_valid) begin
            unique case (state_reg.parse)
                PS_IDLE: begin
                    if (rx_data == state_reg.lead_char) begin
                        state_next.parse  = PS_COLLECT;
                        state_next.rx_len = 4'h0;
                    end
                end
                PS_COLLECT: begin
                    if (rx_data == CH_CR) begin
                        state_next.parse = PS_IDLE;
                        // Keep-alive: broadcast, silent
                        if (state_reg.rx_len == 4'h2 &&
                            state_reg.rx_buf[0] == CH_STAR &&
                            state_reg.rx_buf[1] == CH_STAR) begin
                            state_next.countdown = state_reg.timeout;
                        end else if (state_reg.rx_len >= 4'h2 && h0[4] &&
                                     h1[4] && {h0[3:0], h1[3:0]} ==
                                     state_reg.module_addr) begin
                            state_next.tx_idx    = 4'h0;
                            state_next.tx_buf[1] = hex_chr(
                                state_reg.module_addr[7:4]);
                            state_next.tx_buf[2] = hex_chr(
                                state_reg.module_addr[3:0]);
                            if (state_reg.rx_len == 4'h8 &&
                                state_reg.rx_buf[2] == CH_SET &&
                                (state_reg.rx_buf[3] == CH_ZERO ||
                                 state_reg.rx_buf[3] == CH_ONE) &&
                                h2[4] && h3[4] && h4[4] && h5[4] &&
                                new_to != 8'h00) begin
                                state_next.wd_enable =
                                    state_reg.rx_buf[3] == CH_ONE;
                                state_next.timeout   = new_to;
                                state_next.safe_output_pattern =
                                    new_safe;
                                state_next.countdown = new_to;
                                state_next.host_failed = 1'b0;
                                state_next.tx_buf[0] = CH_BANG;
                                state_next.tx_buf[3] = CH_CR;
                                state_next.tx_len    = 4'h4;
                                ev_set[EV_SET]       = 1'b1;
                            end else if (state_reg.rx_len == 4'h3 &&
                                state_reg.rx_buf[2] == CH_READ) begin
                                state_next.tx_buf[0] = CH_BANG;
                                state_next.tx_buf[3] = state_reg.wd_enable
                                    ? CH_ONE : CH_ZERO;
                                state_next.tx_buf[4] = hex_chr(
                                    state_reg.timeout[7:4]);
                                state_next.tx_buf[5] = hex_chr(
                                    state_reg.timeout[3:0]);
                                state_next.tx_buf[6] = CH_ZERO;
                                state_next.tx_buf[7] = CH_ZERO;
                                state_next.tx_buf[8] = CH_CR;
                                state_next.tx_len    = 4'h9;
                            end else begin
                                state_next.tx_buf[0] = CH_QUERY;
                                state_next.tx_buf[3] = CH_CR;
                                state_next.tx_len    = 4'h4;
                                ev_set[EV_BAD]       = 1'b1;
                            end
                        end
                    end else if (state_reg.rx_len == 4'(RX_MAX)) begin
                        state_next.parse = PS_SKIP;  // Overlong, drop
                    end else begin
                        state_next.rx_buf[state_reg.rx_len[2:0]] = rx_data;
                        state_next.rx_len = state_reg.rx_len + 4'h1;
                    end
                end
                PS_SKIP: begin
                    if (rx_data == CH_CR) begin
                        state_next.parse = PS_IDLE;
                    end
                end
                default: state_next.parse = PS_IDLE;
            endcase
        end

        // Bus slave: single-cycle answer, ack dropped the cycle after
        if (bus_req) begin
            state_next.ack = 1'b1;
            unique case (wb_adr_i)
                OFS_CTRL:   state_next.rdata = ctrl_word;
                OFS_STATUS: state_next.rdata = status_word;
                OFS_IRQ:    state_next.rdata = {29'h0, state_reg.irq_status};
                OFS_MASK:   state_next.rdata = {29'h0, state_reg.irq_mask};
                default:    state_next.rdata = 32'h0000_0000;
            endcase
            if (wb_we_i) begin
                if (wb_adr_i == OFS_CTRL && wb_sel_i[0]) begin
                    state_next.module_addr = wb_dat_i[CTRL_ADDR_LSB +: 8];
                end
                if (wb_adr_i == OFS_CTRL && wb_sel_i[1]) begin
                    state_next.lead_char = wb_dat_i[CTRL_LEAD_LSB +: 8];
                end
                if (wb_adr_i == OFS_STATUS && wb_sel_i[0] &&
                    wb_dat_i[ST_FAIL] && !ev_set[EV_EXPIRE]) begin
                    // Expiry in the same cycle wins over the clear
                    state_next.wd_failed = 1'b0;  // Write one to clear
                end
                if (wb_adr_i == OFS_MASK && wb_sel_i[0]) begin
                    state_next.irq_mask = wb_dat_i[EV_WIDTH-1:0];
                end
            end else if (wb_adr_i == OFS_IRQ) begin
                state_next.irq_status = '0;       // Read clears
            end
        end
        // New events win over the read clear
        state_next.irq_status = state_next.irq_status | ev_set;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg                     <= '0;
            state_reg.parse               <= PS_IDLE;
            state_reg.timeout             <= TIMEOUT_RESET;
            state_reg.safe_output_pattern <= SAFE_RESET;
            state_reg.module_addr         <= ADDR_RESET;
            state_reg.lead_char           <= LEAD_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs: forced pattern while the host has failed
    assign dout      = state_reg.host_failed ? state_reg.safe_output_pattern
                                             : dout_normal;
    assign host_fail = state_reg.host_failed;
    assign tx_valid  = state_reg.tx_idx < state_reg.tx_len;
    assign tx_data   = tx_valid ? state_reg.tx_buf[state_reg.tx_idx] : 8'h00;
    assign wb_dat_o  = state_reg.rdata;
    assign wb_ack_o  = state_reg.ack;
    assign irq       = |(state_reg.irq_status & state_reg.irq_mask);
endmodule : hwd_core

// *** test/hwd_host_model.sv ***
/*
 * Host-side model: sends ASCII commands as receive strobes and
 * collects reply bytes, optionally stalling the transmit side.
 * Assumes the same clock as the core.
 */
`timescale 1ns/10ps
module hwd_host_model (
    input  wire logic       clk,
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready
);
    logic       slow;
    logic [7:0] reply_q[$];

    initial begin
        rx_data  = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
        slow     = 1'b0;
    end

    // Collect reply bytes; slow mode stalls every other cycle
    always @(posedge clk) begin
        if (tx_valid && tx_ready)
            reply_q.push_back(tx_data);
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end

    // Whole command back to back, lead char through CR
    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge clk);
            rx_data  <= 8'(s[i]);
            rx_valid <= 1'b1;
        end
        @(posedge clk);
        rx_data  <= ~8'(s[s.len()-1]); // Idle line never shows old char
        rx_valid <= 1'b0;
    endtask : send
endmodule : hwd_host_model

// *** test/hwd_core_sva.sv ***
/*
 * Port checker for hwd_core, bound to every instance.
 * Assumes one clock and the synchronous active-high reset.
 */
`timescale 1ns/10ps
module hwd_core_sva
    import hwd_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [7:0]  rx_data,
    input wire logic        rx_valid,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic [7:0]  dout_normal,
    input wire logic [7:0]  dout,
    input wire logic        host_fail,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking

    // Bus answers exactly one cycle after the request is taken
    chk_ack_answer: assert property (disable iff (reset)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    chk_ack_drop: assert property (disable iff (reset)
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    // Outputs quiet after a reset edge, no disable here on purpose
    chk_reset_quiet: assert property (
        reset |=> !tx_valid && !wb_ack_o && !host_fail && !irq)
        else $error("outputs active after reset");
    chk_safe_out: assert property (disable iff (reset)
        !host_fail && $past(host_fail) == 1'b0 && $stable(dout_normal)
        |-> dout == dout_normal) else $error("dout not normal pattern");
    chk_tx_hold: assert property (disable iff (reset)
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped while stalled");
    chk_reply_lead: assert property (disable iff (reset)
        $rose(tx_valid) |-> tx_data == CH_BANG || tx_data == CH_QUERY)
        else $error("reply starts with wrong char");
    // A reply only ever follows a taken CR
    chk_reply_cause: assert property (disable iff (reset)
        $rose(tx_valid) |-> ($past(rx_valid) && $past(rx_data) == CH_CR)
        || ($past(rx_valid, 2) && $past(rx_data, 2) == CH_CR))
        else $error("reply without command");
    chk_fail_hold: assert property (disable iff (reset)
        $fell(host_fail) |-> ($past(rx_valid) && $past(rx_data) == CH_CR)
        || ($past(rx_valid, 2) && $past(rx_data, 2) == CH_CR))
        else $error("host failure cleared without command");

    cov_query: cover property ($rose(tx_valid) && tx_data == CH_QUERY);
    cov_stall: cover property (tx_valid && !tx_ready);
    cov_irq: cover property ($rose(irq));
    cov_read: cover property (wb_ack_o && !wb_we_i);
endmodule : hwd_core_sva

bind hwd_core hwd_core_sva u_sva (.clk(clk), .reset(reset),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .dout_normal(dout_normal), .dout(dout),
    .host_fail(host_fail), .irq(irq));

// *** test/hwd_core_tb_top.sv ***
/*
 * Self-checking bench for hwd_core: Wishbone tasks, command
 * exchanges through the host model. Expiry is not reached: the
 * package tick is fixed at 100 ms of the 40 MHz clock.
 */
`timescale 1ns/10ps
module hwd_core_tb_top;
    import hwd_pkg::*;
    logic        clk, reset, wb_we, wb_cyc, wb_stb, wb_ack;
    logic        rx_valid, tx_valid, tx_ready, host_fail, irq;
    logic [3:0]  wb_adr, wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r;
    logic [7:0]  rx_data, tx_data, dout_normal, dout;
    int          mismatches, check_count;

    hwd_core dut (.clk(clk), .reset(reset), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_we_i(wb_we),
        .wb_sel_i(wb_sel), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_ack_o(wb_ack), .rx_data(rx_data), .rx_valid(rx_valid),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .dout_normal(dout_normal), .dout(dout), .host_fail(host_fail),
        .irq(irq));
    hwd_host_model host (.clk(clk), .rx_data(rx_data),
        .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic fail(input string m);
        mismatches++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask : fail

    // Classic cycle: hold request until ack is sampled high
    task automatic wb_xfer(input logic [3:0] a, input logic we,
                           input logic [31:0] d, input logic [31:0] exp);
        int n;
        n = 0;
        @(posedge clk);
        wb_adr <= a; wb_we <= we; wb_dat_w <= d;
        wb_sel <= 4'hf; wb_cyc <= 1'b1; wb_stb <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
        check_count++;
        if (wb_ack !== 1'b1) fail("no bus ack");
        else if (!we && wb_dat_r !== exp) fail("register read mismatch");
    endtask : wb_xfer

    // Send a command, wait for the reply to drain, compare its bytes
    task automatic xchg(input string cmd, input string exp);
        int n;
        n = 0;
        host.reply_q.delete();
        host.send(cmd);
        repeat (3) @(posedge clk);
        while (tx_valid !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        check_count++;
        if (host.reply_q.size() != exp.len()) fail("reply length");
        else foreach (host.reply_q[i])
            if (host.reply_q[i] !== 8'(exp[i])) fail("reply byte");
    endtask : xchg

    task automatic chk_irq(input logic exp);
        check_count++;
        if (irq !== exp) fail("irq level");
    endtask : chk_irq

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        results();
    end

    initial begin
        reset = 1'b1; wb_adr = 4'h0; wb_we = 1'b0; wb_dat_w = 32'h0000_0000;
        wb_sel = 4'h0; wb_cyc = 1'b0; wb_stb = 1'b0; dout_normal = 8'h5a;
        mismatches = 0; check_count = 0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        wb_xfer(OFS_CTRL, 1'b0, 32'h0, 32'h0000_7e00);
        wb_xfer(OFS_STATUS, 1'b0, 32'h0, 32'h0000_0000);
        wb_xfer(OFS_IRQ, 1'b0, 32'h0, 32'h0000_0000);
        wb_xfer(OFS_MASK, 1'b0, 32'h0, 32'h0000_0000);
        wb_xfer(4'h2, 1'b1, 32'hffff_ffff, 32'h0);
        wb_xfer(4'h2, 1'b0, 32'h0, 32'h0000_0000);
        wb_xfer(OFS_CTRL, 1'b1, 32'h0000_7e0a, 32'h0);
        wb_xfer(OFS_MASK, 1'b1, 32'(1) << EV_BAD, 32'h0);
        xchg("~0B3\015", "");
        xchg("~0A2112FF\015", "!0A\015");
        wb_xfer(OFS_STATUS, 1'b0, 0, 32'(1) << ST_ENABLED);
        wb_xfer(OFS_IRQ, 1'b0, 0, 32'(1) << EV_SET);
        wb_xfer(OFS_IRQ, 1'b0, 0, 32'h0000_0000);
        host.slow = 1'b1;
        xchg("~0A3\015", "!0A11200\015");
        dout_normal <= 8'hc3;
        xchg("~**\015", "");
        check_count++;
        if (dout !== 8'hc3 || host_fail !== 1'b0) fail("dout not normal");
        xchg("~0A21FF00\015", "!0A\015");
        xchg("~0A3\015", "!0A1FF00\015");
        xchg("~0A210000\015", "?0A\015");
        chk_irq(1'b1);
        wb_xfer(OFS_IRQ, 1'b0, 0, 32'h0000_0006); // Set and bad events
        chk_irq(1'b0);
        host.slow = 1'b0;
        xchg("~0A2005A5\015", "!0A\015");
        xchg("~0A3\015", "!0A00500\015");
        wb_xfer(OFS_STATUS, 1'b0, 0, 32'h0000_0000);
        xchg("~0A5\015", "?0A\015");
        results();
    end
endmodule : hwd_core_tb_top
